// ---- dv/fsmc_fan_model.sv ----
`timescale 1ns/100ps
// behavioural fan: speed follows the high time seen per 240-cycle window,
// tach period count is inversely related, saturating at 255 when stalled
module fsmc_fan_model #(
   parameter int SPEED_K = 24000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pwm,
   input wire logic stall,
   output logic [7:0] tach_count,
   output logic tach_valid
);
   int slot;
   int high;

   // count value for a given high time; no drive means no rotation
   function automatic logic [7:0] period_of(input int h, input logic st);
      int v;
      if (st || h == 0) begin
         return 8'hFF;
      end
      v = SPEED_K / h;
      return (v > 255) ? 8'hFF : 8'(v);
   endfunction

   // one measurement per window, valid pulses for a single cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= 0;
         high <= 0;
         tach_count <= 8'hFF;
         tach_valid <= 1'b0;
      end else if (slot == 239) begin
         slot <= 0;
         high <= 0;
         tach_count <= period_of(high + int'(pwm), stall);
         tach_valid <= 1'b1;
      end else begin
         slot <= slot + 1;
         high <= high + int'(pwm);
         tach_valid <= 1'b0;
      end
   end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`include "fsmc_regs.svh"
module tb;
   import fsmc_pkg::*;
   localparam int BASE = 256;
   // target from 11.25 kHz, 3068 rpm, divider 2
   localparam int TGT = (11250 * 60) / (3068 * 2);
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] fan1_auto_duty = 8'h00;
   logic [7:0] fan2_auto_duty = 8'h00;
   logic [7:0] fan1_tach;
   logic [7:0] fan2_tach;
   logic tach_valid;
   logic fan1_pwm, fan2_pwm, fan1_fail, fan2_fail, spinup_disable, sample_tick;
   logic stall1 = 1'b0;
   logic stall2 = 1'b0;
   logic [31:0] rd, d0, d1;
   logic er;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   int n1, n2;

   always #12.5 pclk = ~pclk;

   fsmc_fan_control #(.BASE_CYCLES(BASE)) uut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fan1_auto_duty(fan1_auto_duty), .fan2_auto_duty(fan2_auto_duty),
      .fan1_tach_count(fan1_tach), .fan2_tach_count(fan2_tach), .tach_valid(tach_valid),
      .fan1_pwm(fan1_pwm), .fan2_pwm(fan2_pwm), .fan1_fail(fan1_fail),
      .fan2_fail(fan2_fail), .spinup_disable(spinup_disable), .sample_tick(sample_tick));
   // fans measured with divider 2 in the count constant
   fsmc_fan_model fan1 (.pclk(pclk), .presetn(presetn), .pwm(fan1_pwm), .stall(stall1),
      .tach_count(fan1_tach), .tach_valid(tach_valid));
   fsmc_fan_model fan2 (.pclk(pclk), .presetn(presetn), .pwm(fan2_pwm), .stall(stall2),
      .tach_count(fan2_tach), .tach_valid());

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // apb master: hold everything until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // counts high cycles of both pins over one full pwm period
   task automatic high_time();
      n1 = 0;
      n2 = 0;
      repeat (240) begin
         @(posedge pclk);
         n1 += int'(fan1_pwm === 1'b1);
         n2 += int'(fan2_pwm === 1'b1);
      end
   endtask

   task automatic next_tick();
      do begin
         @(posedge pclk);
      end while (sample_tick !== 1'b1);
   endtask

   // hang guard, the run needs about 10k cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 40000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and read back
      apb(`FSMC_ADDR_SMOOTHING, 1'b0, 0); check(rd, 32'h0000_0010);
      apb(`FSMC_ADDR_MAIN_CONFIG, 1'b0, 0); check(rd, 32'h0000_0000);
      apb(`FSMC_ADDR_FAN1_TARGET, 1'b0, 0); check(rd, 32'h0000_00FF);
      check({31'h0, spinup_disable}, 32'h0000_0000);
      // spin-up disable follows bit 7
      apb(`FSMC_ADDR_SMOOTHING, 1'b1, 32'h0000_00FF);
      apb(`FSMC_ADDR_SMOOTHING, 1'b0, 0); check(rd, 32'h0000_00FF);
      check({31'h0, spinup_disable}, 32'h0000_0001);
      apb(`FSMC_ADDR_SMOOTHING, 1'b1, 32'h0000_0010);
      // unmapped write errors, read-only write silently ignored
      apb(12'h004, 1'b1, 32'h0000_00AA); check({31'h0, er}, 32'h0000_0001);
      apb(`FSMC_ADDR_AUTO_DUTY, 1'b1, 32'h0000_5555); check({31'h0, er}, 0);
      // every duty code on both nibbles
      for (int c = 0; c < 16; c++) begin
         apb(`FSMC_ADDR_DUTY_SELECT, 1'b1, 32'((15 - c) * 16 + c));
         repeat (4) @(posedge pclk);
         apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0);
         check(rd, 32'(((15 - c) * 16 << 8) | (c * 16)));
         high_time();
         check(32'(n1), 32'(c * 16));
         check(32'(n2), 32'((15 - c) * 16));
      end
      // smoothing left off when the auto bit goes on, so both duties jump to the inputs
      fan1_auto_duty <= 8'd100;
      fan2_auto_duty <= 8'd200;
      apb(`FSMC_ADDR_MAIN_CONFIG, 1'b1, 32'h0000_0080);
      repeat (4) @(posedge pclk);
      apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0); check(rd, 32'h0000_C864);
      // tick period halves per rate code
      for (int r = 0; r < 8; r++) begin
         apb(`FSMC_ADDR_SMOOTHING, 1'b1, 32'(r << 2));
         next_tick();
         next_tick();
         n1 = 0;
         do begin
            @(posedge pclk);
            n1++;
         end while (sample_tick !== 1'b1);
         check(32'(n1), 32'(BASE >> r));
      end
      // both fans stepping by the ramp size, opposite directions
      for (int r = 0; r < 4; r++) begin
         apb(`FSMC_ADDR_SMOOTHING, 1'b1, 32'((r << 5) | 8'h13));
         // targets move only once smoothing is on, else both fans jump
         fan1_auto_duty <= 8'd240;
         fan2_auto_duty <= 8'd0;
         next_tick();
         repeat (2) @(posedge pclk);
         apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0);
         d0 = rd;
         next_tick();
         repeat (2) @(posedge pclk);
         apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0);
         d1 = rd;
         check(32'(d1[7:0] - d0[7:0]), 32'(1 << r));
         check(32'(d0[15:8] - d1[15:8]), 32'(1 << r));
      end
      apb(`FSMC_ADDR_SMOOTHING, 1'b1, 32'h0000_0010);
      repeat (4) @(posedge pclk);
      apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0); check(rd, 32'h0000_00F0);
      // closed-loop: fan runs too fast at full drive, drive must fall
      apb(`FSMC_ADDR_FAN1_TARGET, 1'b1, 32'(TGT));
      apb(`FSMC_ADDR_MAIN_CONFIG, 1'b1, 32'h0000_0020);
      apb(`FSMC_ADDR_FAN1_TARGET, 1'b0, 0); check(rd, 32'(TGT));
      repeat (2400) @(posedge pclk);
      apb(`FSMC_ADDR_AUTO_DUTY, 1'b0, 0);
      check(32'(rd[7:0] < 8'd240 && rd[7:0] > 8'd200), 32'h0000_0001);
      // stall flags only the fan in speed mode, not sticky
      stall1 <= 1'b1;
      stall2 <= 1'b1;
      repeat (600) @(posedge pclk);
      apb(`FSMC_ADDR_STATUS, 1'b0, 0); check(rd, 32'h0000_0001);
      check({30'h0, fan2_fail, fan1_fail}, 32'h0000_0001);
      stall1 <= 1'b0;
      stall2 <= 1'b0;
      repeat (600) @(posedge pclk);
      apb(`FSMC_ADDR_STATUS, 1'b0, 0); check(rd, 32'h0000_0000);
      // second fan alone in speed mode, first back on its duty code
      apb(`FSMC_ADDR_FAN2_TARGET, 1'b1, 32'(TGT));
      apb(`FSMC_ADDR_MAIN_CONFIG, 1'b1, 32'h0000_0040);
      stall2 <= 1'b1;
      repeat (600) @(posedge pclk);
      apb(`FSMC_ADDR_STATUS, 1'b0, 0); check(rd, 32'h0000_0002);
      check({30'h0, fan2_fail, fan1_fail}, 32'h0000_0002);
      tally_and_finish();
   end
endmodule

// ---- rtl/fsmc_fan_control.sv ----
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "fsmc_regs.svh"
module fsmc_fan_control
   import fsmc_pkg::*;
#(
   parameter int BASE_CYCLES = `FSMC_BASE_RATE_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] fan1_auto_duty,
   input wire logic [7:0] fan2_auto_duty,
   input wire logic [7:0] fan1_tach_count,
   input wire logic [7:0] fan2_tach_count,
   input wire logic tach_valid,
   output logic fan1_pwm,
   output logic fan2_pwm,
   output logic fan1_fail,
   output logic fan2_fail,
   output logic spinup_disable,
   output logic sample_tick
);
   typedef struct packed {
      fsmc_regs_t regs;
      logic [7:0] duty1;
      logic [7:0] duty2;
      logic fail1;
      logic fail2;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic spin_dis;
      logic tick;
      logic pwm1;
      logic pwm2;
   } fsmc_state_t;

   fsmc_state_t st;
   fsmc_state_t next_st;
   fsmc_apb_req_t req;
   logic pwm1_raw;
   logic pwm2_raw;
   logic tick_raw;

   assign req.paddr = paddr;
   assign req.pwrite = pwrite;
   assign req.psel = psel;
   assign req.penable = penable;
   assign req.pwdata = pwdata;

   // every decoded word; anything else answers with an error
   function automatic logic addr_mapped(input logic [11:0] a);
      case (a)
         `FSMC_ADDR_MAIN_CONFIG, `FSMC_ADDR_FAN1_TARGET, `FSMC_ADDR_FAN2_TARGET,
         `FSMC_ADDR_DUTY_SELECT, `FSMC_ADDR_SMOOTHING, `FSMC_ADDR_AUTO_DUTY,
         `FSMC_ADDR_TACH_COUNT, `FSMC_ADDR_STATUS: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   // step size in slots from the two-bit ramp code
   function automatic logic [7:0] ramp_step(input logic [1:0] code);
      ramp_step = 8'd1 << code;
   endfunction

   // move prev toward target by step, never overshooting
   function automatic logic [7:0] step_toward(input logic [7:0] prev,
                                               input logic [7:0] target,
                                               input logic [7:0] step);
      if (target > prev) begin
         step_toward = (target - prev > step) ? prev + step : target;
      end else if (target < prev) begin
         step_toward = (prev - target > step) ? prev - step : target;
      end else begin
         step_toward = prev;
      end
   endfunction

   // mode of one fan from auto bit and its mode bit
   function automatic fsmc_mode_t fan_mode(input logic [7:0] cfg, input logic rpm_bit);
      if (cfg[`FSMC_CFG_AUTO_BIT]) begin
         fan_mode = FSMC_MODE_AUTO;
      end else if (rpm_bit) begin
         fan_mode = FSMC_MODE_RPM;
      end else begin
         fan_mode = FSMC_MODE_DUTY;
      end
   endfunction

   // next duty of one fan for its mode
   function automatic logic [7:0] fan_duty(input fsmc_mode_t mode,
                                           input logic [7:0] prev,
                                           input logic [7:0] auto_duty,
                                           input logic smooth_en,
                                           input logic [7:0] step,
                                           input logic [3:0] code,
                                           input logic [7:0] target,
                                           input logic [7:0] tach,
                                           input logic upd,
                                           input logic tvalid);
      logic [7:0] capped;
      capped = (auto_duty > `FSMC_PWM_SLOTS) ? `FSMC_PWM_SLOTS : auto_duty;
      fan_duty = prev;
      case (mode)
         FSMC_MODE_AUTO: begin
            if (smooth_en) begin
               if (upd) begin
                  fan_duty = step_toward(prev, capped, step);
               end
            end else begin
               fan_duty = capped;
            end
         end
         FSMC_MODE_DUTY: begin
            fan_duty = 8'({4'd0, code} * `FSMC_SLOTS_PER_CODE);
         end
         FSMC_MODE_RPM: begin
            if (tvalid) begin
               if (tach > target) begin
                  fan_duty = (prev < `FSMC_PWM_SLOTS) ? prev + 8'd1 : prev;
               end else if (tach < target) begin
                  fan_duty = (prev > 8'd0) ? prev - 8'd1 : prev;
               end
            end
         end
         default: begin
            fan_duty = prev;
         end
      endcase
   endfunction

   fsmc_sample_tick #(
      .BASE_CYCLES(BASE_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .rate_code(st.regs.smoothing[`FSMC_SMO_RATE_HI:`FSMC_SMO_RATE_LO]),
      .tick(tick_raw)
   );

   fsmc_pwm_slot u_pwm1 (
      .pclk(pclk),
      .presetn(presetn),
      .duty(st.duty1),
      .pwm_out(pwm1_raw),
      .frame_start()
   );

   fsmc_pwm_slot u_pwm2 (
      .pclk(pclk),
      .presetn(presetn),
      .duty(st.duty2),
      .pwm_out(pwm2_raw),
      .frame_start()
   );

   // main next-state logic: apb slave, duties, failure flags
   always_comb begin
      fsmc_mode_t m1;
      fsmc_mode_t m2;
      logic [7:0] step;
      logic wr;
      logic rd;
      m1 = FSMC_MODE_AUTO;
      m2 = FSMC_MODE_AUTO;
      step = 8'd0;
      wr = 1'b0;
      rd = 1'b0;
      next_st = st;
      // write lands at the access edge, where the master sees pready high
      wr = req.psel && req.penable && st.ready && req.pwrite;
      rd = req.psel && !req.penable && !req.pwrite;
      // slave answers one cycle after setup; pready pulses in access
      next_st.ready = req.psel && !req.penable;
      // error decided at setup so it stands together with pready
      next_st.slverr = req.psel && !req.penable && !addr_mapped(req.paddr);
      next_st.tick = tick_raw;
      // pwm pins registered here so they leave straight from flops
      next_st.pwm1 = pwm1_raw;
      next_st.pwm2 = pwm2_raw;
      if (wr) begin
         case (req.paddr)
            `FSMC_ADDR_MAIN_CONFIG: next_st.regs.main_cfg = req.pwdata[7:0];
            `FSMC_ADDR_FAN1_TARGET: next_st.regs.fan1_target = req.pwdata[7:0];
            `FSMC_ADDR_FAN2_TARGET: next_st.regs.fan2_target = req.pwdata[7:0];
            `FSMC_ADDR_DUTY_SELECT: next_st.regs.duty_select = req.pwdata[7:0];
            `FSMC_ADDR_SMOOTHING: next_st.regs.smoothing = req.pwdata[7:0];
            // read-only and unmapped words take no write
            default: begin
            end
         endcase
      end
      if (rd) begin
         next_st.rdata = 32'h0000_0000;
         case (req.paddr)
            `FSMC_ADDR_MAIN_CONFIG: next_st.rdata[7:0] = st.regs.main_cfg;
            `FSMC_ADDR_FAN1_TARGET: next_st.rdata[7:0] = st.regs.fan1_target;
            `FSMC_ADDR_FAN2_TARGET: next_st.rdata[7:0] = st.regs.fan2_target;
            `FSMC_ADDR_DUTY_SELECT: next_st.rdata[7:0] = st.regs.duty_select;
            `FSMC_ADDR_SMOOTHING: next_st.rdata[7:0] = st.regs.smoothing;
            `FSMC_ADDR_AUTO_DUTY: next_st.rdata[15:0] = {st.duty2, st.duty1};
            `FSMC_ADDR_TACH_COUNT: next_st.rdata[15:0] = {fan2_tach_count, fan1_tach_count};
            `FSMC_ADDR_STATUS: next_st.rdata[1:0] = {st.fail2, st.fail1};
            default: next_st.slverr = 1'b1;
         endcase
      end
      // auto bit picks temperature or software control
      // clear mode bit means duty-code mode
      // set mode bit means speed mode
      m1 = fan_mode(st.regs.main_cfg, st.regs.main_cfg[`FSMC_CFG_FAN1_RPM_BIT]);
      m2 = fan_mode(st.regs.main_cfg, st.regs.main_cfg[`FSMC_CFG_FAN2_RPM_BIT]);
      step = ramp_step(st.regs.smoothing[`FSMC_SMO_RAMP_HI:`FSMC_SMO_RAMP_LO]);
      next_st.duty1 = fan_duty(m1, st.duty1, fan1_auto_duty,
                               st.regs.smoothing[`FSMC_SMO_FAN1_EN_BIT], step,
                               st.regs.duty_select[3:0], st.regs.fan1_target,
                               fan1_tach_count, tick_raw, tach_valid);
      next_st.duty2 = fan_duty(m2, st.duty2, fan2_auto_duty,
                               st.regs.smoothing[`FSMC_SMO_FAN2_EN_BIT], step,
                               st.regs.duty_select[7:4], st.regs.fan2_target,
                               fan2_tach_count, tick_raw, tach_valid);
      // failure only on saturated count in speed mode
      next_st.fail1 = (m1 == FSMC_MODE_RPM) && (fan1_tach_count == `FSMC_COUNT_SAT);
      next_st.fail2 = (m2 == FSMC_MODE_RPM) && (fan2_tach_count == `FSMC_COUNT_SAT);
      next_st.spin_dis = st.regs.smoothing[`FSMC_SMO_SPINUP_DIS_BIT];
   end

   // one register stage for the whole state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.regs.main_cfg <= `FSMC_CFG_RESET;
         st.regs.smoothing <= `FSMC_SMO_RESET;
         st.regs.duty_select <= `FSMC_DUTY_RESET;
         st.regs.fan1_target <= `FSMC_TARGET_RESET;
         st.regs.fan2_target <= `FSMC_TARGET_RESET;
         st.duty1 <= 8'h00;
         st.duty2 <= 8'h00;
         st.fail1 <= 1'b0;
         st.fail2 <= 1'b0;
         st.rdata <= 32'h0000_0000;
         st.ready <= 1'b0;
         st.slverr <= 1'b0;
         st.spin_dis <= 1'b0;
         st.tick <= 1'b0;
         st.pwm1 <= 1'b0;
         st.pwm2 <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.slverr;
   assign fan1_pwm = st.pwm1;
   assign fan2_pwm = st.pwm2;
   assign fan1_fail = st.fail1;
   assign fan2_fail = st.fail2;
   assign spinup_disable = st.spin_dis;
   assign sample_tick = st.tick;

   // software sets auto bit last; nothing to enforce here

   AST_SPINUP: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 spinup_disable == $past(st.regs.smoothing[7]))
      else $error("spin-up disable does not follow bit 7");
   AST_DUTY_CODE: assert property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7:5] == 3'b000
      |=> st.duty1 == 8'({4'd0, $past(st.regs.duty_select[3:0])} * 8'd16))
      else $error("fan 1 duty does not match code");
   AST_HIGH_NIBBLE: assert property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7:6] == 2'b00
      |=> st.duty2 == 8'({4'd0, $past(st.regs.duty_select[7:4])} * 8'd16))
      else $error("fan 2 duty does not match high nibble");
   AST_NO_SMOOTH: assert property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7] && !st.regs.smoothing[0] && fan1_auto_duty <= 8'd240
      |=> st.duty1 == $past(fan1_auto_duty))
      else $error("unsmoothed duty not applied at once");
   AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7] && st.regs.smoothing[0] && !tick_raw |=> $stable(st.duty1))
      else $error("smoothed duty moved without update");
   AST_STEP_SIZE: assert property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7] && st.regs.smoothing[0] && tick_raw
      && fan1_auto_duty > st.duty1 + 8'd8 && fan1_auto_duty <= 8'd240
      |=> st.duty1 == $past(st.duty1) + (8'd1 << $past(st.regs.smoothing[6:5])))
      else $error("ramp step size wrong");
   AST_RPM_UP: assert property (@(posedge pclk) disable iff (!presetn)
      !st.regs.main_cfg[7] && st.regs.main_cfg[5] && tach_valid
      && fan1_tach_count > st.regs.fan1_target && st.duty1 < 8'd240
      |=> st.duty1 == $past(st.duty1) + 8'd1)
      else $error("slow fan drive not raised");
   AST_RPM_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
      !st.regs.main_cfg[7] && st.regs.main_cfg[5] && tach_valid
      && fan1_tach_count < st.regs.fan1_target && st.duty1 > 8'd0
      |=> st.duty1 == $past(st.duty1) - 8'd1)
      else $error("fast fan drive not lowered");
   AST_RPM_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !st.regs.main_cfg[7] && st.regs.main_cfg[5] && !tach_valid |=> $stable(st.duty1))
      else $error("speed mode duty moved without tach update");
   AST_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
      fan1_fail |-> $past(fan1_tach_count) == 8'hFF && $past(st.regs.main_cfg[5]))
      else $error("failure flag without saturated count");
   AST_FAIL2: assert property (@(posedge pclk) disable iff (!presetn)
      fan2_fail |-> $past(fan2_tach_count) == 8'hFF && $past(st.regs.main_cfg[6])
      && !$past(st.regs.main_cfg[7]))
      else $error("fan 2 failure flag without saturated count");
   AST_DUTY_MAX: assert property (@(posedge pclk) disable iff (!presetn)
      st.duty1 <= 8'd240 && st.duty2 <= 8'd240)
      else $error("duty beyond 240 slots");

   COV_AUTO_SMOOTH: cover property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7] && st.regs.smoothing[0] && tick_raw);
   COV_DUTY_MODE: cover property (@(posedge pclk) disable iff (!presetn)
      st.regs.main_cfg[7:5] == 3'b000 && st.regs.duty_select[3:0] == 4'hF);
   COV_RPM_FAIL: cover property (@(posedge pclk) disable iff (!presetn) fan1_fail);
   COV_FAN2_FAIL: cover property (@(posedge pclk) disable iff (!presetn) fan2_fail);
endmodule

// ---- rtl/fsmc_pkg.sv ----
package fsmc_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic psel;
      logic penable;
      logic [31:0] pwdata;
   } fsmc_apb_req_t;

   typedef enum logic [1:0] {
      FSMC_MODE_AUTO = 2'b00,
      FSMC_MODE_DUTY = 2'b01,
      FSMC_MODE_RPM = 2'b10
   } fsmc_mode_t;

   typedef struct packed {
      logic [7:0] main_cfg;
      logic [7:0] smoothing;
      logic [7:0] duty_select;
      logic [7:0] fan1_target;
      logic [7:0] fan2_target;
   } fsmc_regs_t;
endpackage

// ---- rtl/fsmc_pwm_slot.sv ----
`timescale 1ns/100ps
`include "fsmc_regs.svh"
// one fan pwm output; period of 240 slots, high while slot < duty
module fsmc_pwm_slot
   import fsmc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] duty,
   output logic pwm_out,
   output logic frame_start
);
   typedef struct packed {
      logic [7:0] slot;
      logic pwm;
      logic start;
   } fsmc_pwm_state_t;

   fsmc_pwm_state_t st;
   fsmc_pwm_state_t next_st;

   // slot counter wraps at 240
   always_comb begin
      next_st = st;
      next_st.start = 1'b0;
      if (st.slot == `FSMC_PWM_SLOTS - 8'd1) begin
         next_st.slot = 8'd0;
         next_st.start = 1'b1;
      end else begin
         next_st.slot = st.slot + 8'd1;
      end
      next_st.pwm = (next_st.slot < duty);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pwm_out = st.pwm;
   assign frame_start = st.start;
endmodule

// ---- rtl/fsmc_regs.svh ----
`ifndef FSMC_REGS_SVH
`define FSMC_REGS_SVH
// register indices; one word each, so the byte address is four times the index
`define FSMC_IDX_FAN1_TARGET 12'h010
`define FSMC_IDX_FAN2_TARGET 12'h011
`define FSMC_IDX_DUTY_SELECT 12'h022
`define FSMC_IDX_SMOOTHING 12'h023
`define FSMC_IDX_MAIN_CONFIG 12'h000
`define FSMC_ADDR_FAN1_TARGET (`FSMC_IDX_FAN1_TARGET << 2)
`define FSMC_ADDR_FAN2_TARGET (`FSMC_IDX_FAN2_TARGET << 2)
`define FSMC_ADDR_DUTY_SELECT (`FSMC_IDX_DUTY_SELECT << 2)
`define FSMC_ADDR_SMOOTHING (`FSMC_IDX_SMOOTHING << 2)
`define FSMC_ADDR_MAIN_CONFIG (`FSMC_IDX_MAIN_CONFIG << 2)
// words of this block only, given directly as byte addresses
`define FSMC_ADDR_AUTO_DUTY 12'h030
`define FSMC_ADDR_TACH_COUNT 12'h034
`define FSMC_ADDR_STATUS 12'h038
// main configuration fields
`define FSMC_CFG_AUTO_BIT 7
`define FSMC_CFG_FAN2_RPM_BIT 6
`define FSMC_CFG_FAN1_RPM_BIT 5
// smoothing configuration fields and reset
`define FSMC_SMO_SPINUP_DIS_BIT 7
`define FSMC_SMO_RAMP_HI 6
`define FSMC_SMO_RAMP_LO 5
`define FSMC_SMO_RATE_HI 4
`define FSMC_SMO_RATE_LO 2
`define FSMC_SMO_FAN2_EN_BIT 1
`define FSMC_SMO_FAN1_EN_BIT 0
`define FSMC_SMO_RESET 8'h10
`define FSMC_CFG_RESET 8'h00
`define FSMC_DUTY_RESET 8'h00
`define FSMC_TARGET_RESET 8'hFF
// pwm frame and codes
`define FSMC_PWM_SLOTS 8'd240
`define FSMC_SLOTS_PER_CODE 8'd16
`define FSMC_COUNT_SAT 8'hFF
`define FSMC_RPM_DUTY_INIT 8'd240
// sample timing: 87.5 Hz at code 000, period in ns, then cycles at 25 ns
`define FSMC_CLK_PERIOD_NS 25
`define FSMC_BASE_RATE_PERIOD_NS 11428571
`define FSMC_BASE_RATE_CYCLES (`FSMC_BASE_RATE_PERIOD_NS / `FSMC_CLK_PERIOD_NS)
`endif

// ---- rtl/fsmc_sample_tick.sv ----
`timescale 1ns/100ps
`include "fsmc_regs.svh"
// update strobe, rate doubling per code of the sample rate field
module fsmc_sample_tick
   import fsmc_pkg::*;
#(
   parameter int BASE_CYCLES = `FSMC_BASE_RATE_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] rate_code,
   output logic tick
);
   typedef struct packed {
      logic [23:0] cnt;
      logic tick;
   } fsmc_tick_state_t;

   fsmc_tick_state_t st;
   fsmc_tick_state_t next_st;
   logic [23:0] limit;

   // each code step halves the period; floor keeps at least one cycle
   always_comb begin
      limit = 24'(BASE_CYCLES) >> rate_code;
      if (limit == 24'd0) begin
         limit = 24'd1;
      end
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt >= limit - 24'd1) begin
         next_st.cnt = 24'd0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 24'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule
